// [src/busbar_sup_pkg.sv]
package busbar_sup_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CT_SENS_OFS = 8'h04;
  localparam logic [7:0] CT_SLOPE_OFS = 8'h08;
  localparam logic [7:0] CT_DELAY_OFS = 8'h0C;
  localparam logic [7:0] BAD_DELAY_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] MEAS_SEL_OFS = 8'h18;
  localparam logic [7:0] MEAS_DATA_OFS = 8'h1C;
  localparam logic [7:0] DIS_STATE_OFS = 8'h20;
  localparam logic [7:0] BLOCK_OFS = 8'h24;
  // control and status field positions
  localparam int CTRL_TOL_BIT = 0;
  localparam int STAT_DIFF_DIS_BIT = 0;
  localparam int STAT_BF_DIS_BIT = 1;
  localparam int STAT_INIT_BIT = 2;
  localparam int STAT_ANY_BAD_BIT = 3;
  localparam int STAT_ANY_CT_BIT = 4;
  // setting limits and reset values
  localparam logic [15:0] SENS_MIN = 16'h0032;
  localparam logic [15:0] SENS_MAX = 16'h1388;
  localparam logic [15:0] SENS_RST = 16'h01F4;
  localparam logic [15:0] SLOPE_MIN = 16'h0028;
  localparam logic [15:0] SLOPE_MAX = 16'h0050;
  localparam logic [15:0] SLOPE_RST = 16'h0028;
  localparam logic [15:0] DELAY_MIN = 16'h0064;
  localparam logic [15:0] DELAY_MAX = 16'hEA60;
  localparam logic [15:0] DELAY_RST = 16'h03E8;
  localparam logic TOL_RST = 1'b0;
  // timing: 1 ms tick at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// [src/ms_delay_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module ms_delay_timer
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic tick, // one-cycle 1 ms pulse
  input wire logic cond, // triggering condition
  input wire logic [15:0] delay, // delay in ms
  output logic expired // condition held for delay
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic reach;

  // counts whole ticks, so the first partial ms counts as a full one
  assign reach = (count_reg >= delay);
  assign count_next = !cond ? 16'h0000 : (tick && !reach) ? count_reg + 16'h0001 : count_reg;

  // restart from zero once the condition drops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= 16'h0000;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      count_reg <= count_next;
      expired <= cond && (count_next >= delay);
    end
  end
endmodule
`default_nettype wire

// [src/busbar_ct_isolator_sup.sv]
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module busbar_ct_isolator_sup
  import busbar_sup_pkg::*;
#(
  parameter int NSEC = 2,
  parameter int NDIS = 4,
  parameter int NBAY = 2,
  parameter int NVIN = 2,
  parameter int MW = 16,
  parameter int TICK_DIV = busbar_sup_pkg::TICK_CYCLES
)
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [NSEC*3*MW-1:0] sec_idiff, // diff per section, phase
  input wire logic [NSEC*3*MW-1:0] sec_ibias, // bias per section, phase
  input wire logic [NSEC-1:0] sec_join, // bit i: section i joined to i+1
  input wire logic [NBAY*6*MW-1:0] bay_meas, // mag, angle per phase
  input wire logic [NVIN*3*MW-1:0] vin_meas, // phase voltage magnitudes
  input wire logic [NDIS-1:0] dis_open, // disconnector open pins
  input wire logic [NDIS-1:0] dis_closed, // disconnector closed pins
  output logic [NDIS-1:0] dis_state, // last valid closed state
  output logic [NSEC-1:0] elem_block, // measuring element blocked
  output logic diff_disabled, // differential disabled
  output logic bf_disabled // breaker failure disabled
);
  localparam int NMEAS = NBAY * 6 + NVIN * 3 + NSEC * 6;

  // settings and bus state
  logic tol_reg;
  logic [15:0] sens_reg;
  logic [15:0] slope_reg;
  logic [15:0] ct_delay_reg;
  logic [15:0] bad_delay_reg;
  logic [15:0] meas_sel_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic init_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [NDIS-1:0] open_s1_reg;
  logic [NDIS-1:0] open_s2_reg;
  logic [NDIS-1:0] closed_s1_reg;
  logic [NDIS-1:0] closed_s2_reg;
  logic [NSEC-1:0] ct_over;
  logic [NSEC-1:0] ct_expired;
  logic [NDIS-1:0] dis_bad;
  logic [NDIS-1:0] dis_expired;
  logic [NSEC-1:0] bad_block;
  logic [NSEC-1:0] block_next;
  logic any_bad;
  logic disabled_next;
  logic addr_ok;
  logic cfg_write;
  logic [31:0] rd_next;
  logic [MW-1:0] meas_word;
  logic [NMEAS*MW-1:0] meas_flat;
  logic [NSEC*6*MW-1:0] sec_rep;

  // keep a written setting within its documented range
  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < {16'h0000, lo})
      clamp = lo;
    else if (v > {16'h0000, hi})
      clamp = hi;
    else
      clamp = v[15:0];
  endfunction

  // lowest section below s whose join bit is set, else s; the root of s's chain only while no unjoined break lies between
  function automatic int sec_root(input logic [NSEC-1:0] jn, input int s);
    int r;
    r = s;
    for (int k = NSEC - 1; k > 0; k--)
    begin
      if (k <= r && jn[k-1])
        r = k - 1;
      else if (k <= r)
        r = r;
    end
    sec_root = r;
  endfunction

  // point above characteristic: id*100 > base*100 + slope*bias
  function automatic logic above(input logic [MW-1:0] id, input logic [MW-1:0] ib,
                                 input logic [15:0] base, input logic [15:0] k);
    logic [39:0] lhs;
    logic [39:0] rhs;
    lhs = 40'(id) * 40'd100;
    rhs = 40'(base) * 40'd100 + 40'(k) * 40'(ib);
    above = lhs > rhs;
  endfunction

  // AHB address phase decode, single zero-wait slave
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign cfg_write = wr_pend_reg && (wr_addr_reg != MEAS_SEL_OFS);

  // 1 ms time base; divider kept as a parameter so simulation can shorten it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_reg <= (tick_cnt_reg == 32'(TICK_DIV - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_DIV - 1)) ? 32'h00000000 : tick_cnt_reg + 32'h1;
    end
  end

  // register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tol_reg <= TOL_RST;
      sens_reg <= SENS_RST;
      slope_reg <= SLOPE_RST;
      ct_delay_reg <= DELAY_RST;
      bad_delay_reg <= DELAY_RST;
      meas_sel_reg <= 16'h0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr;
      if (wr_pend_reg)
      begin
        case (wr_addr_reg)
          CTRL_OFS: tol_reg <= hwdata[CTRL_TOL_BIT];
          CT_SENS_OFS: sens_reg <= clamp(hwdata, SENS_MIN, SENS_MAX);
          CT_SLOPE_OFS: slope_reg <= clamp(hwdata, SLOPE_MIN, SLOPE_MAX);
          CT_DELAY_OFS: ct_delay_reg <= clamp(hwdata, DELAY_MIN, DELAY_MAX);
          BAD_DELAY_OFS: bad_delay_reg <= clamp(hwdata, DELAY_MIN, DELAY_MAX);
          MEAS_SEL_OFS: meas_sel_reg <= hwdata[15:0];
          default: meas_sel_reg <= meas_sel_reg;
        endcase
      end
    end
  end

  // status pins pass two flops before anything looks at them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      open_s1_reg <= '1; // idle as open: two zeros would look like a faulty pair
      open_s2_reg <= '1;
      closed_s1_reg <= '0;
      closed_s2_reg <= '0;
    end
    else if (ce)
    begin
      open_s1_reg <= dis_open;
      open_s2_reg <= open_s1_reg;
      closed_s1_reg <= dis_closed;
      closed_s2_reg <= closed_s1_reg;
    end
  end

  // faulty unless exactly one of the pair is set
  assign dis_bad = ~(open_s2_reg ^ closed_s2_reg);
  assign any_bad = |dis_bad;

  // per-disconnector bad-state timers
  for (genvar d = 0; d < NDIS; d++)
  begin : g_dis
    ms_delay_timer u_bad_tmr
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .tick(tick_reg),
      .cond(dis_bad[d]),
      .delay(bad_delay_reg),
      .expired(dis_expired[d])
    );
  end

  // supervision never waits for a trip, it runs on every cycle
  for (genvar s = 0; s < NSEC; s++)
  begin : g_sec
    logic [2:0] ph_over;
    for (genvar p = 0; p < 3; p++)
    begin : g_ph
      assign ph_over[p] = above(sec_idiff[(s*3+p)*MW +: MW], sec_ibias[(s*3+p)*MW +: MW],
                                sens_reg, slope_reg);
    end
    assign ct_over[s] = |ph_over;

    ms_delay_timer u_ct_tmr
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .tick(tick_reg),
      .cond(ct_over[s]),
      .delay(ct_delay_reg),
      .expired(ct_expired[s])
    );

    // disconnector d belongs to section d mod NSEC
    logic [NDIS-1:0] own_exp;
    for (genvar d = 0; d < NDIS; d++)
    begin : g_own
      assign own_exp[d] = dis_expired[d] && ((d % NSEC) == s);
    end
    assign bad_block[s] = (|own_exp) && !tol_reg;

    // each section reports the values of the section sec_root picks for it
    for (genvar p = 0; p < 3; p++)
    begin : g_rep
      assign sec_rep[(s*6+p)*MW +: MW] = sec_idiff[(sec_root(sec_join, s)*3+p)*MW +: MW];
      assign sec_rep[(s*6+3+p)*MW +: MW] = sec_ibias[(sec_root(sec_join, s)*3+p)*MW +: MW];
    end
  end

  assign block_next = ct_expired | bad_block;

  // power-up or setting change opens an init window; a fault there disables
  assign disabled_next = (init_reg || diff_disabled) && any_bad;

  // topology: valid pairs update at once; a faulty pair holds the last valid
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      init_reg <= 1'b1;
      dis_state <= '0;
      elem_block <= '0;
      diff_disabled <= 1'b0;
      bf_disabled <= 1'b0;
    end
    else if (ce)
    begin
      for (int d = 0; d < NDIS; d++)
      begin
        if (!dis_bad[d])
          dis_state[d] <= closed_s2_reg[d];
      end
      elem_block <= block_next;
      diff_disabled <= disabled_next;
      bf_disabled <= disabled_next;
      if (cfg_write)
        init_reg <= 1'b1;
      else if (tick_reg)
        init_reg <= 1'b0;
    end
  end

  // measured values: bays, then voltage inputs, then sections
  assign meas_flat = {sec_rep, vin_meas, bay_meas};
  assign meas_word = (meas_sel_reg < 16'(NMEAS)) ? meas_flat[meas_sel_reg*MW +: MW] : '0;

  // read mux, captured at the address phase so data stands in the data phase
  always_comb
  begin
    rd_next = 32'h00000000;
    case (haddr)
      CTRL_OFS: rd_next[CTRL_TOL_BIT] = tol_reg;
      CT_SENS_OFS: rd_next[15:0] = sens_reg;
      CT_SLOPE_OFS: rd_next[15:0] = slope_reg;
      CT_DELAY_OFS: rd_next[15:0] = ct_delay_reg;
      BAD_DELAY_OFS: rd_next[15:0] = bad_delay_reg;
      STATUS_OFS:
      begin
        rd_next[STAT_DIFF_DIS_BIT] = diff_disabled;
        rd_next[STAT_BF_DIS_BIT] = bf_disabled;
        rd_next[STAT_INIT_BIT] = init_reg;
        rd_next[STAT_ANY_BAD_BIT] = any_bad;
        rd_next[STAT_ANY_CT_BIT] = |ct_over;
      end
      MEAS_SEL_OFS: rd_next[15:0] = meas_sel_reg;
      MEAS_DATA_OFS: rd_next[MW-1:0] = meas_word;
      DIS_STATE_OFS: rd_next[NDIS-1:0] = dis_state;
      BLOCK_OFS: rd_next[NSEC-1:0] = elem_block;
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite)
        hrdata <= rd_next;
    end
  end
endmodule
`default_nettype wire

// [tb/busbar_sup_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module busbar_sup_checker
  import busbar_sup_pkg::*;
#(
  parameter int NSEC = 2,
  parameter int NDIS = 4,
  parameter int TICK_DIV = 10
)
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [7:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [NDIS-1:0] dis_open, // open pins
  input wire logic [NDIS-1:0] dis_closed, // closed pins
  input wire logic [NDIS-1:0] dis_state, // held state
  input wire logic [NSEC-1:0] elem_block, // blocks
  input wire logic diff_disabled, // diff off
  input wire logic bf_disabled // bf off
);
  logic [7:0] bad_hist;
  int age;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // fault history and age; no legal delay can block in under 99 ms
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bad_hist <= '0;
      age <= 0;
    end
    else
    begin
      bad_hist <= {bad_hist[6:0], ~&(dis_open ^ dis_closed)};
      age <= age + 1;
    end
  sequence rd_at(logic [7:0] a);
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr == a;
  endsequence
  ready_high_a: assert property (hreadyout) else $error("ready low");
  resp_okay_a: assert property (!hresp) else $error("response not okay");
  disables_equal_a: assert property (diff_disabled == bf_disabled)
    else $error("disable outputs differ");
  state_update_a: assert property (((dis_state ^ $past(dis_state)) &
    (~($past(dis_open, 3) ^ $past(dis_closed, 3)) | (dis_state ^ $past(dis_closed, 3))))
    == '0) else $error("state taken from bad pair");
  block_delay_a: assert property (elem_block != '0 |-> age >= 99 * TICK_DIV)
    else $error("element blocked too early");
  disable_cause_a: assert property ($rose(diff_disabled) |-> bad_hist != '0)
    else $error("disable without bad pair");
  disable_clear_a: assert property (bad_hist == '0 |-> !diff_disabled)
    else $error("disable outlived fault");
  state_read_a: assert property (rd_at(DIS_STATE_OFS) ##1 $stable(dis_state)
    |-> hrdata == 32'(dis_state)) else $error("state read wrong");
  unmapped_read_a: assert property (rd_at(8'h40) |=> hrdata == '0)
    else $error("unmapped read not zero");
endmodule
bind busbar_ct_isolator_sup busbar_sup_checker #(.NSEC(NSEC), .NDIS(NDIS), .TICK_DIV(TICK_DIV))
  u_busbar_sup_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .dis_open, .dis_closed, .dis_state, .elem_block, .diff_disabled,
  .bf_disabled);
`default_nettype wire

// [tb/field_model.sv]
`timescale 1ns/100ps
`default_nettype none
module field_model
(
  input wire logic [3:0] closed_want, // wanted closed
  input wire logic [3:0] bad_want, // pairs made bad
  input wire logic bad_both, // both made or lost
  input wire logic [15:0] id_val, // section 0 diff
  input wire logic [15:0] ib_val, // section 0 bias
  output logic [3:0] dis_open, // open contacts
  output logic [3:0] dis_closed, // closed contacts
  output logic [95:0] sec_idiff, // diff words
  output logic [95:0] sec_ibias, // bias words
  output logic [191:0] bay_meas, // bay words
  output logic [95:0] vin_meas // voltage words
);
  // a bad pair has both contacts made or both lost
  assign dis_open = (~closed_want & ~bad_want) | (bad_want & {4{bad_both}});
  assign dis_closed = (closed_want & ~bad_want) | (bad_want & {4{bad_both}});
  // section 1 has its own small load so a join shows
  assign sec_idiff = {{3{16'h0007}}, {3{id_val}}};
  assign sec_ibias = {{3{16'h0009}}, {3{ib_val}}};
  // distinct words so a wrong select is seen
  always_comb
  begin
    for (int i = 0; i < 12; i++)
      bay_meas[i*16 +: 16] = 16'hB000 + 16'(i);
    for (int i = 0; i < 6; i++)
      vin_meas[i*16 +: 16] = 16'hC000 + 16'(i);
  end
endmodule
`default_nettype wire

// [tb/busbar_ct_isolator_sup_test.sv]
`timescale 1ns/100ps
`default_nettype none
module busbar_ct_isolator_sup_test;
  import busbar_sup_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, bad_both = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00, sec_join = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [3:0] closed_want = 4'h5, bad_want = 4'h0, dis_open, dis_closed, dis_state;
  logic [15:0] id_val = 16'h0, ib_val = 16'h0;
  logic hreadyout, hresp, diff_disabled, bf_disabled;
  logic [1:0] elem_block;
  logic [95:0] sec_idiff, sec_ibias, vin_meas;
  logic [191:0] bay_meas;
  int failures = 0;
  int samples_checked = 0;
  // free-running bus clock
  always #4 hclk = ~hclk;
  busbar_ct_isolator_sup #(.TICK_DIV(10)) u_busbar_ct_isolator_sup (.hclk, .hresetn,
    .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sec_idiff, .sec_ibias, .sec_join,
    .bay_meas, .vin_meas, .dis_open, .dis_closed, .dis_state, .elem_block,
    .diff_disabled, .bf_disabled);
  field_model u_field_model (.closed_want, .bad_want, .bad_both, .id_val, .ib_val,
    .dis_open, .dis_closed, .sec_idiff, .sec_ibias, .bay_meas, .vin_meas);
  task automatic step(int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one edge, then as many as the slave stalls; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    step(1);
    while (hreadyout !== 1'b1)
    begin
      n++;
      failures += (n > 20);
      if (n > 20)
        end_of_test();
      step(1);
    end
  endtask
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // disables and blocks as one nibble, awaited under a bound
  task automatic wait_out(logic [3:0] exp, int lim);
    int n;
    n = 0;
    while ({diff_disabled, bf_disabled, elem_block} !== exp && n < lim)
    begin
      step(1);
      n++;
    end
    check({28'h0, diff_disabled, bf_disabled, elem_block}, {28'h0, exp});
    if ({diff_disabled, bf_disabled, elem_block} !== exp && lim > 0)
      end_of_test();
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    step(5);
    hresetn <= 1'b1;
    step(1);
  endtask
  task automatic test_settings();
    do_reset();
    rd_chk(CT_SENS_OFS, 32'h1F4);
    rd_chk(CT_SLOPE_OFS, 32'h28);
    rd_chk(CT_DELAY_OFS, 32'h3E8);
    rd_chk(BAD_DELAY_OFS, 32'h3E8);
    rd_chk(CTRL_OFS, 32'h0);
    wr(CT_SENS_OFS, 32'h1389);
    rd_chk(CT_SENS_OFS, 32'h1388);
    wr(CT_SLOPE_OFS, 32'h27);
    rd_chk(CT_SLOPE_OFS, 32'h28);
    wr(CT_DELAY_OFS, 32'h63);
    rd_chk(CT_DELAY_OFS, 32'h64);
    wr(BAD_DELAY_OFS, 32'hEA61);
    rd_chk(BAD_DELAY_OFS, 32'hEA60);
    rd_chk(DIS_STATE_OFS, 32'h5);
    rd_chk(8'h40, 32'h0);
    $display("settings test done");
  endtask
  task automatic test_power_up();
    bad_both <= 1'b1;
    bad_want <= 4'h4;
    do_reset();
    wait_out(4'hC, 20);
    bad_want <= 4'h0;
    wait_out(4'h0, 20);
    step(20);
    bad_want <= 4'h4;
    step(30);
    wait_out(4'h0, 0);
    wr(CT_SLOPE_OFS, 32'h32);
    wait_out(4'hC, 20);
    bad_want <= 4'h0;
    wait_out(4'h0, 20);
    $display("power-up test done");
  endtask
  task automatic test_bad_state();
    do_reset();
    wr(BAD_DELAY_OFS, 32'h64);
    step(20);
    bad_both <= 1'b0;
    bad_want <= 4'h1;
    step(950);
    check({28'h0, dis_state}, 32'h5);
    wait_out(4'h0, 0);
    wait_out(4'h1, 150);
    bad_want <= 4'h0;
    do_reset();
    wr(CTRL_OFS, 32'h1);
    wr(BAD_DELAY_OFS, 32'h64);
    step(20);
    bad_want <= 4'h1;
    step(1200);
    wait_out(4'h0, 0);
    check({28'h0, dis_state}, 32'h5);
    bad_want <= 4'h0;
    closed_want <= 4'h6;
    step(4);
    check({28'h0, dis_state}, 32'h6);
    $display("bad state test done");
  endtask
  task automatic test_ct();
    do_reset();
    wr(CT_SENS_OFS, 32'h32);
    wr(CT_DELAY_OFS, 32'h64);
    ib_val <= 16'h0064;
    id_val <= 16'h005A;
    step(1200);
    wait_out(4'h0, 0);
    id_val <= 16'h005B;
    step(500);
    id_val <= 16'h0000;
    step(3);
    id_val <= 16'h005B;
    step(950);
    wait_out(4'h0, 0);
    wait_out(4'h1, 150);
    rd_chk(STATUS_OFS, 32'h10);
    rd_chk(BLOCK_OFS, 32'h1);
    $display("ct test done");
  endtask
  task automatic meas_chk(logic [31:0] sel, logic [31:0] exp);
    wr(MEAS_SEL_OFS, sel);
    rd_chk(MEAS_DATA_OFS, exp);
  endtask
  task automatic test_meas();
    do_reset();
    id_val <= 16'h0011;
    ib_val <= 16'h0022;
    meas_chk(32'h0, 32'hB000);
    meas_chk(32'hB, 32'hB00B);
    meas_chk(32'hC, 32'hC000);
    meas_chk(32'h11, 32'hC005);
    meas_chk(32'h15, 32'h22);
    meas_chk(32'h18, 32'h7);
    meas_chk(32'h1E, 32'h0);
    sec_join <= 2'b01;
    meas_chk(32'h12, 32'h11);
    meas_chk(32'h18, 32'h11);
    $display("measurement test done");
  endtask
  initial
  begin
    test_settings();
    test_power_up();
    test_bad_state();
    test_ct();
    test_meas();
    end_of_test();
  end
endmodule
`default_nettype wire
